/* File: logic/pciu_pkg.sv */
/*
 * Constants and carrier types for the pin change interrupt unit.
 * Assumes one 8-bit register port and three watched pin groups.
 */
package pciu_pkg;

    // ------------------------------------------------------------------
    // group geometry
    // ------------------------------------------------------------------
    localparam int PCIU_NUM_GROUPS = 3;
    localparam int PCIU_GROUP0_PINS = 8;
    localparam int PCIU_GROUP1_PINS = 7;
    localparam int PCIU_GROUP2_PINS = 8;
    localparam int PCIU_LANE_W = 8;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PCIU_ADDR_GROUP_ENABLE = 8'h68;
    localparam logic [7:0] PCIU_ADDR_GROUP0_MASK = 8'h6B;
    localparam logic [7:0] PCIU_ADDR_GROUP1_MASK = 8'h6C;
    localparam logic [7:0] PCIU_ADDR_GROUP2_MASK = 8'h6D;
    localparam logic [7:0] PCIU_ADDR_CHANGE_FLAG = 8'h3B;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int PCIU_BIT_GROUP0 = 0;
    localparam int PCIU_BIT_GROUP1 = 1;
    localparam int PCIU_BIT_GROUP2 = 2;
    localparam logic [7:0] PCIU_ENABLE_VALID = 8'h07;
    localparam logic [7:0] PCIU_FLAG_VALID = 8'h07;
    localparam logic [7:0] PCIU_MASK0_VALID = 8'hFF;
    localparam logic [7:0] PCIU_MASK1_VALID = 8'h7F;
    localparam logic [7:0] PCIU_MASK2_VALID = 8'hFF;
    localparam logic [7:0] PCIU_RESET_VALUE = 8'h00;
    localparam logic [7:0] PCIU_UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pciu_bus_s;

endpackage

/* File: logic/pciu_top.sv */
/*
 * Pin change interrupt unit: change detection on three pin groups,
 * per-pin masks, per-group enables, sticky flags and request lines.
 * Assumes pins arrive synchronous to clk_sys, the core supplies its
 * global interrupt bit and a one-cycle pulse per group when it starts
 * that group's handler.
 */
`timescale 1ns/1ps
module pciu_top
    import pciu_pkg::*;
#(
    parameter int G0_PINS = PCIU_GROUP0_PINS,
    parameter int G1_PINS = PCIU_GROUP1_PINS,
    parameter int G2_PINS = PCIU_GROUP2_PINS
) (
    input  wire logic                 clk_sys,       // system clock
    input  wire logic                 rst_n,         // async reset, low
    input  wire pciu_bus_s            reg_req,       // register request
    output logic [7:0]                reg_rdata,     // read data, +1 cycle
    input  wire logic [G0_PINS-1:0]   group0_watched_pins, // group 0 pins
    input  wire logic [G1_PINS-1:0]   group1_watched_pins, // group 1 pins
    input  wire logic [G2_PINS-1:0]   group2_watched_pins, // group 2 pins
    input  wire logic                 core_global_enable,  // core I bit
    input  wire logic [2:0]           handler_start, // per-group pulse
    output logic [2:0]                vector_request, // per-group request
    output logic [2:0]                group_flag     // flag copy
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] group_enable_control_ff;
    logic [7:0] nxt_group_enable_control;
    logic [2:0][7:0] pin_mask_ff;
    logic [2:0][7:0] nxt_pin_mask;
    logic [2:0] change_flag_ff;
    logic [2:0] nxt_change_flag;
    logic [2:0][7:0] pin_now_ff;
    logic [2:0][7:0] pin_prev_ff;
    logic primed_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [2:0] request_ff;
    logic [2:0] nxt_request;

    // ------------------------------------------------------------------
    // pin lanes, unused lanes held low
    // ------------------------------------------------------------------
    wire [2:0][7:0] pin_lane;
    wire [2:0][7:0] mask_valid;

    assign pin_lane[0] = 8'(group0_watched_pins);
    assign pin_lane[1] = 8'(group1_watched_pins);
    assign pin_lane[2] = 8'(group2_watched_pins);
    assign mask_valid[0] = PCIU_MASK0_VALID;
    assign mask_valid[1] = PCIU_MASK1_VALID;
    assign mask_valid[2] = PCIU_MASK2_VALID;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire sel_enable = reg_req.addr == PCIU_ADDR_GROUP_ENABLE;
    wire sel_flag = reg_req.addr == PCIU_ADDR_CHANGE_FLAG;
    wire [2:0] sel_mask;
    assign sel_mask[0] = reg_req.addr == PCIU_ADDR_GROUP0_MASK;
    assign sel_mask[1] = reg_req.addr == PCIU_ADDR_GROUP1_MASK;
    assign sel_mask[2] = reg_req.addr == PCIU_ADDR_GROUP2_MASK;

    wire wr_enable = reg_req.wr && sel_enable;
    wire wr_flag = reg_req.wr && sel_flag;
    wire [2:0] wr_mask = {3{reg_req.wr}} & sel_mask;
    wire mapped = sel_enable || sel_flag || (|sel_mask);

    // ------------------------------------------------------------------
    // change detection per group
    // ------------------------------------------------------------------
    wire [2:0] group_enable = group_enable_control_ff[2:0];
    wire [2:0][7:0] pin_change;
    wire [2:0] flag_set;
    wire [2:0] flag_w1c;

    genvar g;
    generate
        for (g = 0; g < PCIU_NUM_GROUPS; g++) begin : g_group
            // compare with one clock earlier
            // primed_ff hides the first compare after reset
            assign pin_change[g] = (pin_now_ff[g] ^ pin_prev_ff[g]) &
                                   {8{primed_ff}};
            // masked pins only, group enable gates
            // cleared mask bit blocks its pin
            assign flag_set[g] = group_enable[g] &&
                                 (|(pin_change[g] & pin_mask_ff[g]));
            assign flag_w1c[g] = wr_flag && reg_req.wdata[g];
            // group 2 flag set from bit 2
            // group 1 flag set from bit 1
            // group 0 flag set from bit 0
            // a new change beats any clear
            assign nxt_change_flag[g] = flag_set[g] ||
                (change_flag_ff[g] && !flag_w1c[g] && !handler_start[g]);
            assign nxt_pin_mask[g] = wr_mask[g] ?
                (reg_req.wdata & mask_valid[g]) : pin_mask_ff[g];
            // group 1 needs enable and global bit
            // group 0 needs enable and global bit
            // group 2 needs enable and global bit
            // jump only while both gates are one
            // group 1 drives its own request line
            // group 0 drives its own request line
            assign nxt_request[g] = nxt_change_flag[g] &&
                                    group_enable[g] && core_global_enable;
        end
    endgenerate

    // only bits 2..0 stored, the rest read zero
    assign nxt_group_enable_control = wr_enable ?
        (reg_req.wdata & PCIU_ENABLE_VALID) : group_enable_control_ff;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [7:0] rd_enable = group_enable_control_ff & PCIU_ENABLE_VALID;
    // flag bits 7..3 are zero on read
    wire [7:0] rd_flag = 8'(change_flag_ff) & PCIU_FLAG_VALID;
    // mask 1 bit 7 is never stored nor read
    wire [7:0] rd_mask = sel_mask[0] ? pin_mask_ff[0] :
                         sel_mask[1] ? (pin_mask_ff[1] & PCIU_MASK1_VALID) :
                         pin_mask_ff[2];
    wire [7:0] rd_value = sel_enable ? rd_enable :
                          sel_flag ? rd_flag :
                          mapped ? rd_mask : PCIU_UNMAPPED_READ;
    // read data only in the cycle after the strobe
    assign nxt_rdata = reg_req.rd ? rd_value : PCIU_RESET_VALUE;

    // ------------------------------------------------------------------
    // flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            group_enable_control_ff <= PCIU_RESET_VALUE;
            pin_mask_ff <= '0;
            change_flag_ff <= '0;
        end else begin
            group_enable_control_ff <= nxt_group_enable_control;
            pin_mask_ff <= nxt_pin_mask;
            change_flag_ff <= nxt_change_flag;
        end
    end

    // pin history; the first cycle after reset has no valid history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_now_ff <= '0;
            pin_prev_ff <= '0;
            primed_ff <= 1'b0;
        end else begin
            pin_now_ff <= pin_lane;
            // first sample seeds both stages: no false edge after reset
            pin_prev_ff <= primed_ff ? pin_now_ff : pin_lane;
            primed_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= PCIU_RESET_VALUE;
            request_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
            request_ff <= nxt_request;
        end
    end

    assign reg_rdata = rdata_ff;
    assign vector_request = request_ff;
    assign group_flag = change_flag_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    generate
        for (g = 0; g < PCIU_NUM_GROUPS; g++) begin : g_check
            a_flag_on_change:
                assert property (flag_set[g] |=> change_flag_ff[g])
                else $error("flag not set after enabled change");

            a_change_sets_flag:
                assert property (
                    (group_enable[g] &&
                     |((pin_lane[g] ^ pin_now_ff[g]) & pin_mask_ff[g]) &&
                     primed_ff && !wr_mask[g] && !wr_enable)
                    |=> ##1 change_flag_ff[g])
                else $error("pin change two cycles ago left no flag");

            a_masked_pin_quiet:
                assert property (
                    (!change_flag_ff[g] && pin_mask_ff[g] == 8'h00 &&
                     !wr_mask[g])
                    |=> !change_flag_ff[g])
                else $error("flag rose with all pins masked off");

            a_w1c_clears:
                assert property (
                    (wr_flag && reg_req.wdata[g] && !flag_set[g])
                    |=> !change_flag_ff[g])
                else $error("write one did not clear the flag");

            a_w0_keeps:
                assert property (
                    (wr_flag && !reg_req.wdata[g] && change_flag_ff[g] &&
                     !handler_start[g])
                    |=> change_flag_ff[g])
                else $error("write zero disturbed the flag");

            a_handler_clears:
                assert property (
                    (handler_start[g] && !flag_set[g] && change_flag_ff[g])
                    |=> !change_flag_ff[g] && !request_ff[g])
                else $error("handler start left the flag set");

            a_set_beats_clear:
                assert property (
                    (flag_set[g] && (handler_start[g] || flag_w1c[g]))
                    |=> change_flag_ff[g])
                else $error("new change lost against a clear");

            a_request_gated:
                assert property (
                    request_ff[g] == (change_flag_ff[g] &&
                        $past(group_enable[g]) && $past(core_global_enable)))
                else $error("vector request not flag and both gates");
        end
    endgenerate

    a_flag_rsvd_zero:
        assert property (
            (reg_req.rd && sel_flag) |=> reg_rdata[7:3] == 5'h00 &&
                reg_rdata[2:0] == $past(change_flag_ff))
        else $error("flag read wrong or upper bits not zero");

    a_mask1_bit7_zero:
        assert property (
            (reg_req.rd && sel_mask[1]) |=> !reg_rdata[7])
        else $error("group 1 mask bit 7 read as one");

    a_enable_layout:
        assert property (
            (wr_enable && !reg_req.rd) ##1 (reg_req.rd && sel_enable &&
                !wr_enable)
            |=> reg_rdata == ($past(reg_req.wdata, 2) & 8'h07))
        else $error("enable register lost write or upper bits set");

    a_mask2_roundtrip:
        assert property (
            wr_mask[2] ##1 (reg_req.rd && sel_mask[2] && !wr_mask[2])
            |=> reg_rdata == $past(reg_req.wdata, 2))
        else $error("group 2 mask did not keep its value");

    a_unmapped_zero:
        assert property (
            (reg_req.rd && !mapped) |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");

    // ------------------------------------------------------------------
    // gating and separation checks
    // ------------------------------------------------------------------
    generate
        for (g = 0; g < PCIU_NUM_GROUPS; g++) begin : g_gate
            a_disabled_quiet:
                assert property (
                    (!group_enable[g] && !change_flag_ff[g])
                    |=> !change_flag_ff[g])
                else $error("flag rose while its group was disabled");

            a_request_own_flag:
                assert property (request_ff[g] |-> change_flag_ff[g])
                else $error("request raised without its own flag");

            a_global_withholds:
                assert property (!core_global_enable |=> !request_ff[g])
                else $error("request raised with global bit clear");

            a_enable_withholds:
                assert property (!group_enable[g] |=> !request_ff[g])
                else $error("request raised with group disabled");

            a_request_follows:
                assert property (
                    (change_flag_ff[g] && !flag_w1c[g] && !handler_start[g]
                     && group_enable[g] && core_global_enable)
                    |=> request_ff[g])
                else $error("request missing with flag and both gates");

            a_quiet_pins_no_flag:
                assert property (
                    (!change_flag_ff[g] && pin_now_ff[g] == pin_prev_ff[g])
                    |=> !change_flag_ff[g])
                else $error("flag rose with no pin change");

            a_flag_holds:
                assert property (
                    (change_flag_ff[g] && !flag_w1c[g] && !handler_start[g])
                    |=> change_flag_ff[g])
                else $error("flag dropped with no clear");
        end
    endgenerate

    // ------------------------------------------------------------------
    // register port checks; the three gap checks leave one idle cycle between write and read
    // ------------------------------------------------------------------
    a_rdata_idle:
        assert property (!reg_req.rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");

    a_enable_rsvd_zero:
        assert property (
            (reg_req.rd && sel_enable) |=> reg_rdata[7:3] == 5'h00)
        else $error("enable register upper bits read as one");

    a_enable_gap:
        assert property (
            wr_enable ##1 !wr_enable ##1 (reg_req.rd && sel_enable)
            |=> reg_rdata == ($past(reg_req.wdata, 3) & 8'h07))
        else $error("enable register lost a write");

    a_mask0_gap:
        assert property (
            wr_mask[0] ##1 !wr_mask[0] ##1 (reg_req.rd && sel_mask[0])
            |=> reg_rdata == $past(reg_req.wdata, 3))
        else $error("group 0 mask did not keep its value");

    a_mask1_gap:
        assert property (
            wr_mask[1] ##1 !wr_mask[1] ##1 (reg_req.rd && sel_mask[1])
            |=> reg_rdata == ($past(reg_req.wdata, 3) & 8'h7F))
        else $error("group 1 mask lost bits 6..0");

    a_stray_write:
        assert property (
            (reg_req.wr && !mapped) |=> $stable(group_enable_control_ff) &&
                $stable(pin_mask_ff))
        else $error("unmapped write changed a register");

    a_flag_write_kept:
        assert property (
            wr_flag |=> $stable(group_enable_control_ff) &&
                $stable(pin_mask_ff))
        else $error("flag write disturbed enable or mask");

endmodule // pciu_top

/* File: test/pciu_pin_model.sv */
/*
 * Far-side model: drives the watched pins and the core's handler
 * start pulses.
 * Assumes the caller steps it from the bench's clock.
 */
`timescale 1ns/1ps
module pciu_pin_model (
    input  wire logic clk_sys,               // system clock
    output logic [7:0] group0_watched_pins,  // group 0 pins
    output logic [6:0] group1_watched_pins,  // group 1 pins
    output logic [7:0] group2_watched_pins,  // group 2 pins
    output logic [2:0] handler_start         // per-group pulse
);
    initial begin
        group0_watched_pins = 8'h00;
        group1_watched_pins = 7'h00;
        group2_watched_pins = 8'h00;
        handler_start = 3'h0;
    end

    // one toggle is one logic change, launched at an edge
    task automatic toggle(input int g, input int b);
        @(posedge clk_sys);
        case (g)
            0: group0_watched_pins[b] <= ~group0_watched_pins[b];
            1: group1_watched_pins[b] <= ~group1_watched_pins[b];
            default: group2_watched_pins[b] <= ~group2_watched_pins[b];
        endcase
    endtask

    // core entering a handler: one-cycle pulse
    task automatic fire(input int g);
        @(posedge clk_sys);
        handler_start[g] <= 1'b1;
        @(posedge clk_sys);
        handler_start <= 3'h0;
    endtask
endmodule // pciu_pin_model

/* File: test/pciu_top_tb.sv */
/*
 * Self-checking bench for the pin change interrupt unit.
 * Assumes the register port answers reads one cycle later.
 */
`timescale 1ns/1ps
module pciu_top_tb;
    import pciu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    pciu_bus_s reg_req = '0;
    logic [7:0] reg_rdata, got;
    logic [7:0] g0;
    logic [6:0] g1;
    logic [7:0] g2;
    logic glb = 1'b0;
    logic [2:0] hs, vreq, flag;
    int failures = 0;
    int comparisons = 0;
    logic [7:0] addr_tbl [5] = '{8'h68, 8'h6B, 8'h6C, 8'h6D, 8'h3B};
    logic [7:0] exp_tbl [5] = '{8'h07, 8'hFF, 8'h7F, 8'hFF, 8'h00};

    always #5 clk_sys = ~clk_sys;

    pciu_pin_model i_pciu_pin_model (
        .clk_sys(clk_sys), .group0_watched_pins(g0),
        .group1_watched_pins(g1), .group2_watched_pins(g2),
        .handler_start(hs));

    pciu_top i_pciu_top (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .group0_watched_pins(g0),
        .group1_watched_pins(g1), .group2_watched_pins(g2),
        .core_global_enable(glb), .handler_start(hs),
        .vector_request(vreq), .group_flag(flag));

    // ------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // core global interrupt bit, changed just after an edge
    task automatic set_global(input logic v);
        @(posedge clk_sys);
        glb <= v;
    endtask

    task automatic chk_reg(input string n, input logic [7:0] e,
                           input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic chk_out(input logic [2:0] ef, input logic [2:0] ev);
        chk_reg("group_flag", {5'h00, ef}, {5'h00, flag});
        chk_reg("vector_request", {5'h00, ev}, {5'h00, vreq});
    endtask

    // change launched, then flag lands one edge after it is sampled
    task automatic change(input int g, input int b);
        i_pciu_pin_model.toggle(g, b);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic final_report();
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        final_report();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        set_global(1'b1);
        for (int i = 0; i < 5; i++) begin
            rd(addr_tbl[i], got);
            chk_reg("reset value", 8'h00, got);
        end
        rd(8'h70, got);
        chk_reg("unmapped read", 8'h00, got);
        for (int i = 0; i < 5; i++)
            wr(addr_tbl[i], 8'hFF);
        for (int i = 0; i < 5; i++) begin
            rd(addr_tbl[i], got);
            chk_reg("reserved bits", exp_tbl[i], got);
        end
        // a stray write must not reach the enable or mask registers
        wr(8'h70, 8'h00);
        // each group sets only its own flag and request
        for (int g = 0; g < 3; g++) begin
            change(g, (g == 1) ? 6 : 7);
            chk_out(3'(1 << g), 3'(1 << g));
            rd(8'h3B, got);
            chk_reg("flag register", 8'(1 << g), got);
            wr(8'h3B, 8'(~(1 << g)) & 8'h07);
            #1 chk_out(3'(1 << g), 3'(1 << g));
            wr(8'h3B, 8'(1 << g));
            #1 chk_out(3'h0, 3'h0);
        end
        wr(8'h6B, 8'hFE);
        change(0, 0);
        chk_out(3'h0, 3'h0);
        wr(8'h6B, 8'hFF);
        wr(8'h68, 8'h05);
        change(1, 0);
        chk_out(3'h0, 3'h0);
        wr(8'h68, 8'h07);
        change(1, 0);
        chk_out(3'h2, 3'h2);
        i_pciu_pin_model.fire(1);
        #1 chk_out(3'h0, 3'h0);
        // global bit withholds the request but not the flag
        set_global(1'b0);
        change(2, 3);
        chk_out(3'h4, 3'h0);
        set_global(1'b1);
        repeat (2) @(posedge clk_sys);
        #1 chk_out(3'h4, 3'h4);
        i_pciu_pin_model.fire(2);
        #1 chk_out(3'h0, 3'h0);
        // hardware clear colliding with a fresh change
        change(0, 1);
        i_pciu_pin_model.toggle(0, 1);
        i_pciu_pin_model.fire(0);
        #1 chk_out(3'h1, 3'h1);
        i_pciu_pin_model.fire(0);
        #1 chk_out(3'h0, 3'h0);
        // write-one clear colliding with a fresh change
        i_pciu_pin_model.toggle(0, 4);
        wr(8'h3B, 8'h01);
        #1 chk_out(3'h1, 3'h1);
        wr(8'h3B, 8'h01);
        #1 chk_out(3'h0, 3'h0);
        // reset in mid-run clears flags and registers, pins stay put
        change(2, 5);
        chk_out(3'h4, 3'h4);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        #1 chk_out(3'h0, 3'h0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h6D, got);
        chk_reg("mask 2 after reset", 8'h00, got);
        wr(8'h68, 8'h01);
        rd(8'h68, got);
        chk_reg("enable readback", 8'h01, got);
        wr(8'h6B, 8'h01);
        rd(8'h6B, got);
        chk_reg("mask 0 readback", 8'h01, got);
        wr(8'h6C, 8'hFF);
        rd(8'h6C, got);
        chk_reg("mask 1 readback", 8'h7F, got);
        change(0, 0);
        chk_out(3'h1, 3'h1);
        final_report();
    end
endmodule // pciu_top_tb
